/* File: swdmr_regs.vh */
// timing constants for the supervisor watchdog with manual reset
// assumes a single system clock; every figure is held in its own unit
`ifndef SWDMR_REGS_VH
`define SWDMR_REGS_VH

// system clock period in ns (25 MHz)
`define SWDMR_CLK_PERIOD_NS 40
// internal time base period in ns (1 us tick)
`define SWDMR_TICK_NS 1000
// cycles per time base tick
`define SWDMR_TICK_CYC (`SWDMR_TICK_NS / `SWDMR_CLK_PERIOD_NS)

// manual reset low pulses up to this width are rejected, in ns
`define SWDMR_MR_REJECT_NS 100
// shortest watchdog pulse that must be seen, in ns
`define SWDMR_WD_PULSE_NS 50
// supply dips shorter than this are ignored, in ns (4 us)
`define SWDMR_UV_REJECT_NS 4000

// stable cycles needed: a pulse of the reject width rounds up, plus one
`define SWDMR_MR_FILT_CYC \
  ((`SWDMR_MR_REJECT_NS + `SWDMR_CLK_PERIOD_NS - 1) / `SWDMR_CLK_PERIOD_NS + 1)
`define SWDMR_UV_FILT_CYC \
  ((`SWDMR_UV_REJECT_NS + `SWDMR_CLK_PERIOD_NS - 1) / `SWDMR_CLK_PERIOD_NS + 1)

// reset hold options A..D, minimum values in us
`define SWDMR_HOLD_A_US 1000
`define SWDMR_HOLD_B_US 20000
`define SWDMR_HOLD_C_US 140000
`define SWDMR_HOLD_D_US 1120000

// watchdog period options W..Z, typical values in us
`define SWDMR_WD_W_US 6300
`define SWDMR_WD_X_US 102000
`define SWDMR_WD_Y_US 1600000
`define SWDMR_WD_Z_US 25600000

// option codes
`define SWDMR_SEL_A_W 2'h0
`define SWDMR_SEL_B_X 2'h1
`define SWDMR_SEL_C_Y 2'h2
`define SWDMR_SEL_D_Z 2'h3

// reset values of the reset state and the counters
`define SWDMR_RST_ACTIVE 1'h1
`define SWDMR_CNT_RESET 25'h0000000

`endif

/* File: swdmr_sync.v */
// two flip-flop synchroniser for a group of asynchronous levels
// assumes the inputs come from pins outside the clock domain
`timescale 1ns/100ps
module swdmr_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
)
(
  input wire mclk_i,
  input wire nrst_i,
  input wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);

  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // first stage feeds only the second stage
  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      meta_r <= INIT;
      sync_r <= INIT;
    end
    else
    begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule

/* File: swdmr_filt.v */
// stability filter: output follows the input only after it has held
// the same level for STABLE consecutive clock cycles
// assumes the input is already synchronous to mclk_i
`timescale 1ns/100ps
module swdmr_filt #(
  parameter STABLE = 4,
  parameter CW = 8,
  parameter INIT = 1'b1
)
(
  input wire mclk_i,
  input wire nrst_i,
  input wire level_i,
  output wire level_o
);

  localparam integer LIM_I = STABLE - 1;
  localparam [CW-1:0] LIM = LIM_I[CW-1:0];

  reg level_r;
  reg [CW-1:0] run_r;

  // count cycles of disagreement; any agreement restarts the count,
  // so a short glitch of either polarity never reaches the output
  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      level_r <= INIT;
      run_r <= {CW{1'b0}};
    end
    else if (level_i == level_r)
      run_r <= {CW{1'b0}};
    else if (run_r == LIM)
    begin
      level_r <= level_i;
      run_r <= {CW{1'b0}};
    end
    else
      run_r <= run_r + {{(CW-1){1'b0}}, 1'b1};
  end

  assign level_o = level_r;

endmodule

/* File: swdmr_top.v */
// processor supervisor: manual reset, watchdog and undervoltage request
// combined into one held reset with push-pull and open-drain outputs
// assumes pins are asynchronous; the supply comparator is outside and
// delivers a plain low-supply level; pad logic reports a floating
// watchdog pin as a level
//
// Functional notes
// R01: reset is asserted while the manual reset input stays low
// R02: after manual reset rises, reset holds for the full hold time
// R03: manual reset low pulses of about 100ns are ignored
// R04: an unconnected manual reset input reads high through a pull-up
// R05: reset asserts when the watchdog input idles a whole period
// R06: any watchdog edge, even 50ns wide, or reset clears the timer
// R07: watchdog timer stays zero during reset, counts after release
// R08: floating watchdog input is serviced internally every 7/8 period
// R09: open-drain output pulls low only while reset is asserted
// R10: supply dips shorter than about 4us raise no reset
// R11: hold time is a build option A..D: 1ms, 20ms, 140ms, 1.12s
// R12: watchdog period is a build option W..Z: 6.3ms..25.6s
// R13: processor should set and clear the kick at separate program points
// R14: processor should keep the kick low and pulse it briefly
// R15: at hold expiry reset releases and the watchdog restarts at zero
// R16: reset holds while supply is low and for hold time after
// R17: active-high reset output is always the inverse of active-low
// R18: all reset requests are ORed; any request restarts the hold count
// R19: watchdog input is synchronised before edge detection
`timescale 1ns/100ps
`include "swdmr_regs.vh"
module swdmr_top #(
  parameter [1:0] HOLD_SEL = `SWDMR_SEL_C_Y,
  parameter [1:0] WD_SEL = `SWDMR_SEL_C_Y,
  parameter HOLD_A_US = `SWDMR_HOLD_A_US,
  parameter HOLD_B_US = `SWDMR_HOLD_B_US,
  parameter HOLD_C_US = `SWDMR_HOLD_C_US,
  parameter HOLD_D_US = `SWDMR_HOLD_D_US,
  parameter WD_W_US = `SWDMR_WD_W_US,
  parameter WD_X_US = `SWDMR_WD_X_US,
  parameter WD_Y_US = `SWDMR_WD_Y_US,
  parameter WD_Z_US = `SWDMR_WD_Z_US,
  parameter TICK_CYC = `SWDMR_TICK_CYC
)
(
  input wire mclk_i,
  input wire nrst_i,
  input wire manual_reset_n_in_i,
  input wire watchdog_kick_in_i,
  input wire watchdog_kick_float_i,
  input wire supply_low_i,
  output wire reset_n_o,
  output wire reset_o,
  output wire reset_od_o,
  output wire reset_od_oe_n_o
);

  localparam CW = 25;
  localparam TW = 8;

  // R11
  // hold option select
  localparam HOLD_US = (HOLD_SEL == `SWDMR_SEL_A_W) ? HOLD_A_US :
                       (HOLD_SEL == `SWDMR_SEL_B_X) ? HOLD_B_US :
                       (HOLD_SEL == `SWDMR_SEL_C_Y) ? HOLD_C_US :
                       HOLD_D_US;
  // R12
  // period option select
  localparam WD_US = (WD_SEL == `SWDMR_SEL_A_W) ? WD_W_US :
                     (WD_SEL == `SWDMR_SEL_B_X) ? WD_X_US :
                     (WD_SEL == `SWDMR_SEL_C_Y) ? WD_Y_US :
                     WD_Z_US;

  // the tick phase is unknown at request end, so one extra tick keeps
  // the hold at or above its minimum
  localparam integer WD_M1 = WD_US - 1;
  localparam integer WD_S7 = (WD_US / 8) * 7;
  localparam integer TICK_M1 = TICK_CYC - 1;
  localparam [CW-1:0] HOLD_LIM = HOLD_US[CW-1:0];
  localparam [CW-1:0] WD_LIM = WD_M1[CW-1:0];
  localparam [CW-1:0] WD_SVC = WD_S7[CW-1:0];
  localparam [TW-1:0] TICK_LIM = TICK_M1[TW-1:0];

  localparam ST_RUN = 1'b0;
  localparam ST_HOLD = 1'b1;

  wire mr_n_s;
  wire kick_s;
  wire float_s;
  wire uv_s;
  wire mr_n_f;
  wire uv_f;
  wire req;
  wire kick_edge;

  reg [TW-1:0] div_r;
  reg tick_r;
  reg kick_d_r;
  reg state_r;
  reg state_nxt;
  reg [CW-1:0] hold_r;
  reg [CW-1:0] hold_nxt;
  reg [CW-1:0] wd_r;
  reg [CW-1:0] wd_nxt;
  reg wd_exp_r;
  reg wd_exp_nxt;
  reg rst_act_r;
  reg rst_nxt;
  reg reset_n_r;
  reg reset_od_oe_n_r;
  reg reset_od_r;

  // R04
  // pins synchronised; manual reset idles high so an open pin is inactive
  swdmr_sync #(
    .W(2),
    .INIT(2'h3)
  ) u_sync_hi (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .async_i({manual_reset_n_in_i, watchdog_kick_float_i}),
    .sync_o({mr_n_s, float_s})
  );

  // R19
  // kick and supply level through two flip-flops before any logic
  swdmr_sync #(
    .W(2),
    .INIT(2'h0)
  ) u_sync_lo (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .async_i({watchdog_kick_in_i, supply_low_i}),
    .sync_o({kick_s, uv_s})
  );

  // R03
  // short manual reset lows are filtered out
  swdmr_filt #(
    .STABLE(`SWDMR_MR_FILT_CYC),
    .CW(TW),
    .INIT(1'b1)
  ) u_mr_filt (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .level_i(mr_n_s),
    .level_o(mr_n_f)
  );

  // R10
  // brief supply dips never reach the request logic
  swdmr_filt #(
    .STABLE(`SWDMR_UV_FILT_CYC),
    .CW(TW),
    .INIT(1'b0)
  ) u_uv_filt (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .level_i(uv_s),
    .level_o(uv_f)
  );

  // time base: one pulse per microsecond
  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      div_r <= {TW{1'b0}};
      tick_r <= 1'b0;
    end
    else if (div_r == TICK_LIM)
    begin
      div_r <= {TW{1'b0}};
      tick_r <= 1'b1;
    end
    else
    begin
      div_r <= div_r + {{(TW-1){1'b0}}, 1'b1};
      tick_r <= 1'b0;
    end
  end

  // R06
  // edge detect on the synchronised kick; one clear per level change
  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      kick_d_r <= 1'b0;
    else
      kick_d_r <= kick_s;
  end

  assign kick_edge = kick_s ^ kick_d_r;

  // R18
  // any one cause is enough to request reset
  assign req = uv_f | ~mr_n_f | wd_exp_r;

  // hold sequencer: any active request restarts the hold count
  always @*
  begin
    state_nxt = state_r;
    hold_nxt = hold_r;
    rst_nxt = rst_act_r;
    case (state_r)
      ST_RUN:
      begin
        // R01
        // a request asserts reset at once
        if (req)
        begin
          state_nxt = ST_HOLD;
          hold_nxt = `SWDMR_CNT_RESET;
          rst_nxt = 1'b1;
        end
      end
      ST_HOLD:
      begin
        // R16
        // hold count waits for every request to drop
        if (req)
          hold_nxt = `SWDMR_CNT_RESET;
        // R02
        // full hold time counted after the last cause ends
        else if (tick_r && hold_r == HOLD_LIM)
        begin
          // R15
          // release reset; watchdog restarts from zero below
          state_nxt = ST_RUN;
          hold_nxt = `SWDMR_CNT_RESET;
          rst_nxt = 1'b0;
        end
        else if (tick_r)
          hold_nxt = hold_r + {{(CW-1){1'b0}}, 1'b1};
      end
      default:
      begin
        state_nxt = ST_HOLD;
        hold_nxt = `SWDMR_CNT_RESET;
        rst_nxt = 1'b1;
      end
    endcase
  end

  // watchdog counter
  always @*
  begin
    wd_nxt = wd_r;
    wd_exp_nxt = 1'b0;
    // R07
    // held at zero while reset or a request is active
    if (rst_act_r || req)
      wd_nxt = `SWDMR_CNT_RESET;
    // R06
    // any kick edge clears the timer
    else if (kick_edge)
      wd_nxt = `SWDMR_CNT_RESET;
    // R08
    // floating pin: internal service at seven eighths of the period
    else if (float_s && wd_r >= WD_SVC)
      wd_nxt = `SWDMR_CNT_RESET;
    else if (tick_r)
    begin
      // R05
      // a full idle period raises the request
      if (wd_r == WD_LIM)
      begin
        wd_nxt = `SWDMR_CNT_RESET;
        wd_exp_nxt = 1'b1;
      end
      else
        wd_nxt = wd_r + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // state registers; reset starts in hold, like a power-on reset
  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_r <= ST_HOLD;
      hold_r <= `SWDMR_CNT_RESET;
      wd_r <= `SWDMR_CNT_RESET;
      wd_exp_r <= 1'b0;
      rst_act_r <= `SWDMR_RST_ACTIVE;
    end
    else
    begin
      state_r <= state_nxt;
      hold_r <= hold_nxt;
      wd_r <= wd_nxt;
      wd_exp_r <= wd_exp_nxt;
      rst_act_r <= rst_nxt;
    end
  end

  // output stage: every pin level from its own flip-flop, loaded from
  // the same next value so the three never disagree for a cycle
  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      reset_n_r <= ~`SWDMR_RST_ACTIVE;
      reset_od_oe_n_r <= ~`SWDMR_RST_ACTIVE;
      reset_od_r <= 1'b0;
    end
    else
    begin
      // R17
      // active-low copy is the exact inverse
      reset_n_r <= ~rst_nxt;
      // R09
      // open drain drives low only during reset
      reset_od_oe_n_r <= ~rst_nxt;
      reset_od_r <= 1'b0;
    end
  end

  assign reset_o = rst_act_r;
  assign reset_n_o = reset_n_r;
  assign reset_od_o = reset_od_r;
  assign reset_od_oe_n_o = reset_od_oe_n_r;

endmodule

/* File: swdmr_chk.sv */
// checker for the supervisor reset outputs, seeing top ports only
// assumes one clock domain and the shortened hold and watchdog counts
`timescale 1ns/100ps
module swdmr_chk #(
  parameter HOLD_US = 20,
  parameter WD_US = 80,
  parameter TICK_CYC = 25
)
(
  input wire mclk_i,
  input wire nrst_i,
  input wire manual_reset_n_in_i,
  input wire watchdog_kick_in_i,
  input wire watchdog_kick_float_i,
  input wire supply_low_i,
  input wire reset_n_o,
  input wire reset_o,
  input wire reset_od_o,
  input wire reset_od_oe_n_o
);
  int quiet_r;
  int idle_r;
  int uv_r;
  logic kick_r;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // cycles since manual reset or low supply, since a kick edge, and of low supply
  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      quiet_r <= 0;
      idle_r <= 0;
      uv_r <= 0;
      kick_r <= 1'b0;
    end
    else
    begin
      kick_r <= watchdog_kick_in_i;
      quiet_r <= (!manual_reset_n_in_i || supply_low_i) ? 0 : quiet_r + 1;
      uv_r <= supply_low_i ? uv_r + 1 : 0;
      // reset or a floating pin also clears, as in the timer
      if (reset_o || watchdog_kick_float_i || kick_r != watchdog_kick_in_i)
        idle_r <= 0;
      else
        idle_r <= idle_r + 1;
    end
  end
  a_out_inverse: assert property (reset_n_o == !reset_o)
    else $error("reset outputs not complementary");
  a_od_low: assert property (reset_od_o == 1'b0)
    else $error("open-drain value not low");
  a_od_enable: assert property (reset_od_oe_n_o == reset_n_o)
    else $error("open-drain enable wrong");
  a_mr_assert: assert property (!manual_reset_n_in_i [*8] |-> reset_o)
    else $error("manual reset not asserted");
  a_mr_glitch: assert property ($fell(manual_reset_n_in_i)
    && !reset_o ##1 !manual_reset_n_in_i ##1 manual_reset_n_in_i
    |=> !reset_o [*6])
    else $error("short manual pulse caused reset");
  a_uv_assert: assert property (uv_r >= 110 |-> reset_o)
    else $error("low supply not asserted");
  a_hold_min: assert property ($fell(reset_o) |->
    quiet_r >= HOLD_US * TICK_CYC)
    else $error("reset released before hold time");
  a_wd_bound: assert property (idle_r <= (WD_US + 1) * TICK_CYC + 6)
    else $error("watchdog did not expire");
  a_wd_early: assert property ($rose(reset_o) && quiet_r > 8 |->
    idle_r >= (WD_US - 1) * TICK_CYC)
    else $error("watchdog expired early");
  a_float_svc: assert property (watchdog_kick_float_i && quiet_r > 8 &&
    $past(watchdog_kick_float_i, 8) |-> !$rose(reset_o))
    else $error("floating kick caused reset");
endmodule

/* File: swdmr_cpu.sv */
// processor model that services the watchdog kick line
// assumes the supervisor clock; drives only on the falling edge
`timescale 1ns/100ps
module swdmr_cpu
(
  input wire mclk_i,
  input wire run_i,
  input wire mode_i,
  input wire [15:0] gap_i,
  output logic kick_o
);
  int cnt_r = 0;
  initial kick_o = 1'b0;
  // a stalled program parks the line so the supervisor must time out
  // toggle apart or pulse briefly
  always @(negedge mclk_i)
  begin
    if (run_i && cnt_r >= gap_i)
    begin
      cnt_r <= 0;
      kick_o <= mode_i ? ~kick_o : 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 1;
      if (!mode_i && cnt_r == 1)
        kick_o <= 1'b0;
    end
  end
endmodule

/* File: swdmr_top_tb.sv */
// self-checking bench for the supervisor with a processor model
// assumes shortened hold and watchdog counts and a 4-cycle tick
`timescale 1ns/100ps
module swdmr_top_tb;
  localparam int HOLD = 20;
  localparam int WD = 80;
  localparam int TK = 4;
  logic mclk_i = 0, nrst_i = 0, mr_n = 1, flt = 0, uv = 0;
  logic run = 0, mode = 0;
  logic [15:0] gap = 16'h0020;
  wire kick, rst_n, rst, od, od_oe_n;
  int mismatches = 0, n_compared = 0, n, g;
  initial
  begin
    forever #20 mclk_i = ~mclk_i;
  end
  swdmr_cpu cpu (.mclk_i(mclk_i), .run_i(run), .mode_i(mode),
    .gap_i(gap), .kick_o(kick));
  swdmr_top #(.HOLD_C_US(HOLD), .WD_Y_US(WD), .TICK_CYC(TK)) dut (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .manual_reset_n_in_i(mr_n),
    .watchdog_kick_in_i(kick), .watchdog_kick_float_i(flt),
    .supply_low_i(uv), .reset_n_o(rst_n), .reset_o(rst),
    .reset_od_o(od), .reset_od_oe_n_o(od_oe_n));
  task automatic chk(input string what, input int lo, input int hi,
    input int got);
    n_compared++;
    if (got < lo || got > hi)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi,
        got);
    end
  endtask
  // count falling edges until reset shows the wanted level
  task automatic wait_rst(input logic v, output int c);
    c = 0;
    while (rst !== v && c < 4000)
    begin
      @(negedge mclk_i);
      c++;
    end
  endtask
  // reset must stay off for the whole span
  task automatic quiet(input int cyc, input string what);
    int hit;
    hit = 0;
    repeat (cyc)
    begin
      @(negedge mclk_i);
      // every output stage must show the idle levels together
      if (rst !== 1'b0 || rst_n !== 1'b1 || od_oe_n !== 1'b1 || od !== 1'b0)
        hit++;
    end
    chk(what, 0, 0, hit);
  endtask
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // hang guard at 50000 cycles, well beyond the expected 4300 cycles
  initial
  begin
    #2000000;
    mismatches++;
    summarize();
  end
  // main sequence
  initial
  begin
    n = $urandom(68);
    gap = 16'($urandom_range(20, 120));
    run = 1;
    repeat (20) @(negedge mclk_i);
    nrst_i = 1;
    wait_rst(0, n);
    chk("power-on hold", HOLD * TK, (HOLD + 2) * TK + 10, n);
    $display("power-on hold done");
    mr_n = 0;
    repeat ($urandom_range(10, 40)) @(negedge mclk_i);
    chk("reset in manual", 1, 1, int'(rst === 1'b1));
    chk("low output in manual", 0, 0, int'(rst_n !== 1'b0));
    chk("drain on in manual", 0, 0, int'(od_oe_n !== 1'b0));
    mr_n = 1;
    wait_rst(0, n);
    chk("manual hold", HOLD * TK + 6, (HOLD + 2) * TK + 12, n);
    mr_n = 0;
    @(negedge mclk_i);
    @(negedge mclk_i);
    mr_n = 1;
    quiet(20, "short manual pulse");
    $display("manual reset done");
    // the processor model samples on the falling edge too, so its
    // controls change by non-blocking assignment to avoid a race
    mode <= 1;
    quiet(3 * WD * TK, "toggled kick");
    g = gap;
    run <= 0;
    wait_rst(1, n);
    chk("watchdog expiry", (WD - 1) * TK - g - 2, (WD + 1) * TK + 8, n);
    wait_rst(0, n);
    chk("watchdog hold", HOLD * TK, (HOLD + 2) * TK + 4, n);
    wait_rst(1, n);
    chk("restart from zero", (WD - 1) * TK, (WD + 1) * TK + 4, n);
    mode <= 0;
    run <= 1;
    wait_rst(0, n);
    quiet(2 * WD * TK, "pulsed kick");
    $display("watchdog done");
    mr_n = 0;
    repeat (10) @(negedge mclk_i);
    mr_n = 1;
    run <= 0;
    flt = 1;
    wait_rst(0, n);
    quiet(3 * WD * TK, "floating kick");
    flt = 0;
    run <= 1;
    $display("floating kick done");
    uv = 1;
    quiet(50, "short supply dip");
    uv = 0;
    quiet(120, "after short dip");
    uv = 1;
    repeat (200) @(negedge mclk_i);
    chk("reset in low supply", 1, 1, int'(rst === 1'b1));
    uv = 0;
    wait_rst(0, n);
    chk("supply hold", HOLD * TK + 100, (HOLD + 2) * TK + 115, n);
    $display("supply done");
    summarize();
  end
endmodule
bind swdmr_top swdmr_chk #(.HOLD_US(HOLD_C_US), .WD_US(WD_Y_US),
  .TICK_CYC(TICK_CYC)) u_chk (.mclk_i(mclk_i), .nrst_i(nrst_i),
  .manual_reset_n_in_i(manual_reset_n_in_i),
  .watchdog_kick_in_i(watchdog_kick_in_i),
  .watchdog_kick_float_i(watchdog_kick_float_i),
  .supply_low_i(supply_low_i), .reset_n_o(reset_n_o), .reset_o(reset_o),
  .reset_od_o(reset_od_o), .reset_od_oe_n_o(reset_od_oe_n_o));
